// ---- itc_counter.sv ----
/*
  one 16-bit timer counter channel, binary or bcd, modes 0 to 5.
  assumes: control and byte writes arrive as one-cycle strobes;
  the count clock is the block clock.
*/
`timescale 1ns/1ps
module itc_counter
  import itc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ctrl_we_i,
  input wire logic [5:0] ctrl_i,
  input wire logic latch_i,
  input wire logic data_we_i,
  input wire logic data_re_i,
  input wire logic [7:0] data_i,
  input wire logic gate_i,
  output logic [7:0] data_o,
  output logic [7:0] status_o,
  output logic out_o,
  output logic wrap_o
);
  logic [1:0] acc_r;
  itc_mode_t mode_r;
  logic bcd_r;
  logic [15:0] init_r;
  logic [15:0] cnt_r;
  logic [15:0] latch_r;
  logic latched_r;
  logic wr_hi_r;
  logic rd_hi_r;
  logic null_r;
  logic load_r;
  logic armed_r;
  logic gate_d_r;
  logic out_r;
  logic [15:0] dec;
  logic [15:0] dec2;
  logic [15:0] cnt_src;
  logic gate_rise;
  logic one;

  function automatic logic [15:0] sub1(input logic [15:0] v,
                                       input logic b);
    logic [15:0] r;
    r = v - 16'h0001;
    if (b) begin
      if (v[3:0] == 4'h0) r[3:0] = 4'h9;
      if (v[3:0] == 4'h0 && v[7:4] == 4'h0) r[7:4] = 4'h9;
      if (v[7:0] == 8'h00 && v[11:8] == 4'h0) r[11:8] = 4'h9;
      if (v[11:0] == 12'h000 && v[15:12] == 4'h0) r[15:12] = 4'h9;
      if (v[3:0] != 4'h0) r = {v[15:4], v[3:0] - 4'h1};
      else if (v[7:4] != 4'h0) r = {v[15:8], v[7:4] - 4'h1, 4'h9};
      else if (v[11:8] != 4'h0) r = {v[15:12], v[11:8] - 4'h1, 8'h99};
      else if (v[15:12] != 4'h0) r = {v[15:12] - 4'h1, 12'h999};
      else r = 16'h9999;
    end
    return r;
  endfunction

  assign gate_rise = gate_i && !gate_d_r;
  assign dec = sub1(cnt_r, bcd_r);
  assign dec2 = sub1(dec, bcd_r);
  assign one = (cnt_r == 16'h0001);
  assign cnt_src = (mode_r == ITC_M3) ? dec2 : dec;

  // ------------------------------------------------------------
  // control word and count loading
  // ------------------------------------------------------------
  // load on write
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      acc_r <= `ITC_ACC_BOTH;
      mode_r <= ITC_M0;
      bcd_r <= 1'b0;
      init_r <= 16'h0000;
      wr_hi_r <= 1'b0;
      null_r <= 1'b1;
      load_r <= 1'b0;
    end else begin
      load_r <= 1'b0;
      if (ctrl_we_i) begin
        acc_r <= ctrl_i[5:4];
        if (ctrl_i[2]) mode_r <= itc_mode_t'({1'b0, 1'b1, ctrl_i[1]});
        else mode_r <= itc_mode_t'(ctrl_i[3:1]);
        bcd_r <= ctrl_i[0];
        wr_hi_r <= 1'b0;
        null_r <= 1'b1;
      end else if (data_we_i) begin
        unique case (acc_r)
          `ITC_ACC_LSB: begin
            init_r <= {8'h00, data_i};
            load_r <= 1'b1;
          end
          `ITC_ACC_MSB: begin
            init_r <= {data_i, 8'h00};
            load_r <= 1'b1;
          end
          default: begin
            if (!wr_hi_r) begin
              init_r[7:0] <= data_i;
            end else begin
              init_r[15:8] <= data_i;
              load_r <= 1'b1;
            end
            wr_hi_r <= !wr_hi_r;
          end
        endcase
        null_r <= 1'b1;
      end
      if (load_r) null_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // counting engine
  // ------------------------------------------------------------
  // mode behaviour
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_r <= 16'h0000;
      armed_r <= 1'b0;
      gate_d_r <= 1'b0;
      out_r <= 1'b0;
      wrap_o <= 1'b0;
    end else begin
      gate_d_r <= gate_i;
      wrap_o <= 1'b0;
      if (ctrl_we_i) begin
        out_r <= (ctrl_i[3:1] != 3'b000);
        armed_r <= 1'b0;
      end else begin
        unique case (mode_r)
          ITC_M0, ITC_M4: begin
            if (load_r) begin
              cnt_r <= init_r;
              armed_r <= 1'b1;
              out_r <= (mode_r == ITC_M4);
            end else if (gate_i && armed_r) begin
              cnt_r <= dec;
              if (one) begin
                wrap_o <= 1'b1;
                out_r <= (mode_r == ITC_M0);
                armed_r <= (mode_r == ITC_M0);
              end else if (mode_r == ITC_M4) out_r <= 1'b1;
            end
          end
          ITC_M1, ITC_M5: begin
            if (load_r) armed_r <= 1'b1;
            if (gate_rise && (armed_r || load_r)) begin
              cnt_r <= init_r;
              out_r <= (mode_r == ITC_M5);
            end else begin
              cnt_r <= dec;
              if (one) begin
                wrap_o <= 1'b1;
                out_r <= (mode_r == ITC_M1);
              end else if (mode_r == ITC_M5) out_r <= 1'b1;
            end
          end
          default: begin
            if (load_r && !armed_r || gate_rise) begin
              cnt_r <= init_r;
              armed_r <= 1'b1;
              out_r <= 1'b1;
            end else if (gate_i && armed_r) begin
              if (cnt_r == 16'h0002 || one ||
                  (mode_r == ITC_M3 && cnt_r == 16'h0003)) begin
                cnt_r <= init_r;
                wrap_o <= 1'b1;
                out_r <= (mode_r == ITC_M3) ? !out_r : 1'b1;
              end else begin
                cnt_r <= cnt_src;
                if (mode_r == ITC_M2) out_r <= !(dec == 16'h0001);
              end
            end else if (!gate_i) out_r <= 1'b1;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // count latch and read sequencing
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      latch_r <= 16'h0000;
      latched_r <= 1'b0;
      rd_hi_r <= 1'b0;
      data_o <= 8'h00;
      status_o <= 8'h00;
      out_o <= 1'b0;
    end else begin
      out_o <= out_r;
      status_o <= {out_r, null_r, acc_r, mode_r, bcd_r};
      if (latch_i && !latched_r) begin
        latch_r <= cnt_r;
        latched_r <= 1'b1;
      end
      if (ctrl_we_i) rd_hi_r <= 1'b0;
      if (data_re_i) begin
        if (acc_r == `ITC_ACC_BOTH) begin
          rd_hi_r <= !rd_hi_r;
          if (rd_hi_r) latched_r <= 1'b0;
        end else latched_r <= 1'b0;
      end
      if (acc_r == `ITC_ACC_MSB || (acc_r == `ITC_ACC_BOTH && rd_hi_r))
        data_o <= latched_r ? latch_r[15:8] : cnt_r[15:8];
      else
        data_o <= latched_r ? latch_r[7:0] : cnt_r[7:0];
    end
  end
endmodule // itc_counter

// ---- itc_defs.svh ----
/*
  register offsets, field positions and reset values of the interval
  timer control block.
  assumes: included by bare name from the package, the monitor and the testbench.
*/
`ifndef ITC_DEFS_SVH
`define ITC_DEFS_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define ITC_OFS_CTRL_WORD 8'h40
`define ITC_OFS_CNT0 8'h44
`define ITC_OFS_CNT1 8'h48
`define ITC_OFS_CNT2 8'h4C
`define ITC_OFS_DELAY 8'h78
`define ITC_OFS_SYS_PORT 8'h80
`define ITC_OFS_IRQ_STAT 8'h84
`define ITC_OFS_IRQ_MASK 8'h88

// ------------------------------------------------------------
// field positions and values
// ------------------------------------------------------------
`define ITC_SEL_HI 7
`define ITC_SEL_LO 6
`define ITC_ACC_HI 5
`define ITC_ACC_LO 4
`define ITC_MODE_HI 3
`define ITC_MODE_LO 1
`define ITC_BCD_BIT 0
`define ITC_SEL_READBACK 2'h3
`define ITC_ACC_LATCH 2'h0
`define ITC_ACC_LSB 2'h1
`define ITC_ACC_MSB 2'h2
`define ITC_ACC_BOTH 2'h3
`define ITC_SYS_RESET 8'h00
`define ITC_SYS_WR_MASK 8'h0F
`define ITC_DELAY_RESET 16'h0000
`define ITC_REFRESH_DIV 8'h0E
`define ITC_IRQ_BITS 3

`endif

// ---- itc_pkg.sv ----
/*
  types of the interval timer control block.
  assumes: itc_defs.svh is on the include path.
*/
package itc_pkg;
  `include "itc_defs.svh"

  typedef enum logic [2:0] {
    ITC_M0 = 3'b000,
    ITC_M1 = 3'b001,
    ITC_M2 = 3'b010,
    ITC_M3 = 3'b011,
    ITC_M4 = 3'b100,
    ITC_M5 = 3'b101
  } itc_mode_t;

  typedef enum logic [1:0] {
    ITC_ACC_ST_LOW = 2'b00,
    ITC_ACC_ST_HIGH = 2'b01
  } itc_byte_st_t;
endpackage

// ---- itc_top.sv ----
/*
  interval timer control: control word decode, three counters,
  firmware delay timer and system control port behind apb.
  assumes: apb master per the amba spec, one clock, synchronous reset.
*/
`timescale 1ns/1ps
module itc_top
  import itc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [1:0] gate_i,
  input wire logic serr_i,
  input wire logic iochk_i,
  output logic [2:0] timer_out_o,
  output logic speaker_o,
  output logic nmi_o,
  output logic irq_o
);
  logic [15:0] delay_r;
  logic [7:0] sys_r;
  logic serr_st_r;
  logic iochk_st_r;
  logic refresh_tog_r;
  logic [7:0] refresh_cnt_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [2:0] rb_r;
  logic wr;
  logic rd;
  logic ctrl_we;
  logic [1:0] sel;
  logic [2:0] cnt_ctrl_we;
  logic [2:0] cnt_latch;
  logic [2:0] cnt_we;
  logic [2:0] cnt_re;
  logic [2:0] cnt_gate;
  logic [2:0] cnt_out;
  logic [2:0] cnt_wrap;
  logic [7:0] cnt_data [3];
  logic [7:0] cnt_stat [3];
  logic [2:0] irq_ev;
  logic [31:0] rdata;
  logic hit;

  assign wr = psel_i && penable_i && pwrite_i;
  assign rd = psel_i && penable_i && !pwrite_i;
  assign ctrl_we = wr && (paddr_i == `ITC_OFS_CTRL_WORD);
  assign sel = pwdata_i[`ITC_SEL_HI:`ITC_SEL_LO];

  // ------------------------------------------------------------
  // control word decode
  // ------------------------------------------------------------
  // target decode
  always_comb begin
    cnt_ctrl_we = 3'b000;
    cnt_latch = 3'b000;
    if (ctrl_we) begin
      if (sel == `ITC_SEL_READBACK) begin
        // read-back: bit 5 low latches count, bits 3:1 pick counters
        if (!pwdata_i[5]) cnt_latch = pwdata_i[3:1];
      end else if (pwdata_i[5:4] == `ITC_ACC_LATCH) begin
        cnt_latch[sel] = 1'b1;
      end else begin
        cnt_ctrl_we[sel] = 1'b1;
      end
    end
  end

  assign cnt_gate = {sys_r[0], gate_i};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_cnt
      assign cnt_we[g] = wr && (paddr_i == `ITC_OFS_CNT0 + 8'(4 * g));
      assign cnt_re[g] = rd && (paddr_i == `ITC_OFS_CNT0 + 8'(4 * g));
      itc_counter u_cnt (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ctrl_we_i(cnt_ctrl_we[g]),
        .ctrl_i(pwdata_i[5:0]),
        .latch_i(cnt_latch[g]),
        .data_we_i(cnt_we[g]),
        .data_re_i(cnt_re[g]),
        .data_i(pwdata_i[7:0]),
        .gate_i(cnt_gate[g]),
        .data_o(cnt_data[g]),
        .status_o(cnt_stat[g]),
        .out_o(cnt_out[g]),
        .wrap_o(cnt_wrap[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // read-back status selection
  // ------------------------------------------------------------
  // status armed
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rb_r <= 3'b000;
    end else begin
      if (ctrl_we && sel == `ITC_SEL_READBACK && !pwdata_i[4])
        rb_r <= rb_r | pwdata_i[3:1];
      for (int i = 0; i < 3; i++) begin
        if (cnt_re[i] && rb_r[i]) rb_r[i] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // firmware delay timer
  // ------------------------------------------------------------
  // countdown to zero
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      delay_r <= `ITC_DELAY_RESET;
    end else if (wr && paddr_i == `ITC_OFS_DELAY) begin
      delay_r <= pwdata_i[15:0];
    end else if (delay_r != 16'h0000) begin
      delay_r <= delay_r - 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // system control port
  // ------------------------------------------------------------
  // reset zero
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sys_r <= `ITC_SYS_RESET;
    end else if (wr && paddr_i == `ITC_OFS_SYS_PORT) begin
      sys_r <= pwdata_i[7:0] & `ITC_SYS_WR_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      refresh_cnt_r <= 8'h00;
      refresh_tog_r <= 1'b0;
    end else if (refresh_cnt_r == `ITC_REFRESH_DIV) begin
      refresh_cnt_r <= 8'h00;
      refresh_tog_r <= !refresh_tog_r;
    end else begin
      refresh_cnt_r <= refresh_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      serr_st_r <= 1'b0;
      iochk_st_r <= 1'b0;
      nmi_o <= 1'b0;
    end else begin
      serr_st_r <= serr_i;
      iochk_st_r <= iochk_i;
      nmi_o <= (serr_i && sys_r[2]) || (iochk_i && sys_r[3]);
    end
  end

  // ------------------------------------------------------------
  // interrupts: counter wraps, sticky, write one to clear
  // ------------------------------------------------------------
  assign irq_ev = cnt_wrap;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      irq_stat_r <= 3'b000;
      irq_mask_r <= 3'b000;
      irq_o <= 1'b0;
    end else begin
      if (wr && paddr_i == `ITC_OFS_IRQ_STAT)
        irq_stat_r <= (irq_stat_r & ~pwdata_i[2:0]) | irq_ev;
      else
        irq_stat_r <= irq_stat_r | irq_ev;
      if (wr && paddr_i == `ITC_OFS_IRQ_MASK)
        irq_mask_r <= pwdata_i[2:0];
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ------------------------------------------------------------
  // outputs and apb read path
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      timer_out_o <= 3'b000;
      speaker_o <= 1'b0;
    end else begin
      timer_out_o <= cnt_out;
      speaker_o <= cnt_out[2] && sys_r[1];
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    unique case (paddr_i)
      `ITC_OFS_CTRL_WORD: rdata = 32'h0000_0000;
      `ITC_OFS_CNT0: rdata = {24'h0, rb_r[0] ? cnt_stat[0] : cnt_data[0]};
      `ITC_OFS_CNT1: rdata = {24'h0, rb_r[1] ? cnt_stat[1] : cnt_data[1]};
      `ITC_OFS_CNT2: rdata = {24'h0, rb_r[2] ? cnt_stat[2] : cnt_data[2]};
      `ITC_OFS_DELAY: rdata = {16'h0000, delay_r};
      `ITC_OFS_SYS_PORT: rdata = {24'h0, serr_st_r, iochk_st_r,
                                  cnt_out[2], refresh_tog_r, sys_r[3:0]};
      `ITC_OFS_IRQ_STAT: rdata = {29'h0, irq_stat_r};
      `ITC_OFS_IRQ_MASK: rdata = {29'h0, irq_mask_r};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !hit;
      if (psel_i && !penable_i && !pwrite_i) prdata_o <= rdata;
    end
  end
endmodule // itc_top

// ---- itc_top_monitor.sv ----
/*
  concurrent checks on the ports of the interval timer control top.
  assumes: bound to itc_top; one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "itc_defs.svh"
module itc_top_monitor (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [1:0] gate_i,
  input wire logic serr_i,
  input wire logic iochk_i,
  input wire logic [2:0] timer_out_o,
  input wire logic speaker_o,
  input wire logic nmi_o,
  input wire logic irq_o
);
  // ------------------------------------------------------------
  // shadow of the writable port and mask bits
  // ------------------------------------------------------------
  logic [3:0] sys_r;
  logic [2:0] mask_r;
  logic acc_w;
  logic rd_w;
  logic unmapped_w;
  logic nmi_src;
  assign acc_w = psel_i && penable_i;
  assign rd_w = acc_w && !pwrite_i;
  assign unmapped_w = !(paddr_i inside {8'h40, 8'h44, 8'h48, 8'h4C,
                                        8'h78, 8'h80, 8'h84, 8'h88});
  assign nmi_src = (serr_i && sys_r[2]) || (iochk_i && sys_r[3]);
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sys_r <= 4'h0;
    end else if (acc_w && pwrite_i && paddr_i == `ITC_OFS_SYS_PORT) begin
      sys_r <= pwdata_i[3:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mask_r <= 3'h0;
    end else if (acc_w && pwrite_i && paddr_i == `ITC_OFS_IRQ_MASK) begin
      mask_r <= pwdata_i[2:0];
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_ready_zero_wait: assert property (acc_w |-> pready_o)
    else $error("pready missing in access cycle");
  chk_unmapped_err: assert property (acc_w |-> pslverr_o == unmapped_w)
    else $error("pslverr disagrees with address map");
  chk_ctrl_write_only: assert property (
    rd_w && paddr_i == `ITC_OFS_CTRL_WORD |-> prdata_o == 32'h0)
    else $error("control word readable");
  chk_reset_quiet: assert property (
    $rose(reset_n_i) |-> !nmi_o && !speaker_o && !irq_o)
    else $error("output active after reset");
  chk_nmi_cause: assert property (
    nmi_o |-> $past(nmi_src) || $past(nmi_src, 2))
    else $error("nmi without enabled source");
  chk_nmi_raise: assert property (
    $past(nmi_src) && $past(nmi_src, 2) |-> nmi_o)
    else $error("enabled source gives no nmi");
  chk_speaker_off: assert property (
    !$past(sys_r[1]) |-> !speaker_o)
    else $error("speaker active while disabled");
  chk_delay_upper: assert property (
    rd_w && paddr_i == `ITC_OFS_DELAY |-> prdata_o[31:16] == 16'h0)
    else $error("delay timer reserved bits set");
  chk_port_read: assert property (
    rd_w && paddr_i == `ITC_OFS_SYS_PORT |->
      prdata_o[3:0] == $past(sys_r) && prdata_o[31:8] == 24'h0)
    else $error("port read differs from written bits");
  chk_irq_masked: assert property (!$past(|mask_r) |-> !irq_o)
    else $error("irq while all masked");
  cover property (acc_w && pwrite_i && paddr_i == `ITC_OFS_CTRL_WORD
                  && pwdata_i[7:6] == 2'h3);
  cover property (nmi_o);
  cover property (irq_o);
  cover property (pslverr_o);
endmodule // itc_top_monitor

bind itc_top itc_top_monitor i_itc_top_monitor (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .gate_i(gate_i), .serr_i(serr_i),
  .iochk_i(iochk_i), .timer_out_o(timer_out_o), .speaker_o(speaker_o),
  .nmi_o(nmi_o), .irq_o(irq_o));

// ---- itc_top_tb_top.sv ----
/*
  self-checking testbench of the interval timer control block.
  assumes: design files and itc_defs.svh are compiled first.
*/
`timescale 1ns/1ps
`include "itc_defs.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  fail_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module itc_top_tb_top;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic e;
  } itc_note_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] gate = 2'b00;
  logic serr = 1'b0;
  logic iochk = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] tout;
  logic speaker;
  logic nmi;
  logic irq;
  logic [31:0] rq;
  logic [31:0] v;
  logic [31:0] a;
  logic [2:0] md;
  itc_note_t notes[$];
  itc_note_t note;
  int fail_count = 0;
  int comparisons = 0;
  int seed = 90355;

  itc_top i_itc_top (
    .clk_i(clk), .reset_n_i(reset_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .gate_i(gate), .serr_i(serr), .iochk_i(iochk),
    .timer_out_o(tout), .speaker_o(speaker), .nmi_o(nmi), .irq_o(irq));

  always #5 clk = ~clk;

  // ------------------------------------------------------------
  // apb master and read watcher
  // ------------------------------------------------------------
  task automatic end_of_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic xfer(input logic [7:0] ad, input logic w,
                      input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rq = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    xfer(ad, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF,
                    input logic er = 1'b0);
    notes.push_back('{e & m, m, er});
    xfer(ad, 1'b0, 32'h0);
  endtask

  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      note = notes.pop_front();
      `CHK("prdata", note.d, prdata & note.m)
      `CHK("pslverr", note.e, pslverr)
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rd(`ITC_OFS_SYS_PORT, 32'h0, 32'hFFFFFFEF);
    rd(`ITC_OFS_DELAY, 32'h0);
    wr(`ITC_OFS_DELAY, 32'hABCD1000);
    rd(`ITC_OFS_DELAY, 32'h00000FFF);
    rd(`ITC_OFS_DELAY, 32'h00000FFC);
    wr(`ITC_OFS_DELAY, 32'h00000003);
    repeat (6) @(posedge clk);
    rd(`ITC_OFS_DELAY, 32'h0);
    wr(`ITC_OFS_CTRL_WORD, 32'h36);
    rd(`ITC_OFS_CTRL_WORD, 32'h0);
    rd(8'h3C, 32'h0, 32'hFFFFFFFF, 1'b1);
    wr(8'h8C, 32'hFFFFFFFF);
    // every mode code, read back as status
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      md = (i[2] && i[1]) ? {1'b0, i[1:0]} : i[2:0];
      wr(`ITC_OFS_CTRL_WORD, {24'h0, 4'b0001, i[2:0], v[0]});
      wr(`ITC_OFS_CTRL_WORD, 32'hE2);
      rd(`ITC_OFS_CNT0, {24'h0, 4'b0101, md, v[0]}, 32'hFFFFFF7F);
    end
    // latch and byte access orders, counter 1 gated off
    wr(`ITC_OFS_CTRL_WORD, 32'h70);
    wr(`ITC_OFS_CNT1, 32'h34);
    wr(`ITC_OFS_CNT1, 32'h12);
    wr(`ITC_OFS_CTRL_WORD, 32'h40);
    rd(`ITC_OFS_CNT1, 32'h34);
    rd(`ITC_OFS_CNT1, 32'h12);
    wr(`ITC_OFS_CTRL_WORD, 32'h50);
    wr(`ITC_OFS_CNT1, 32'h77);
    wr(`ITC_OFS_CTRL_WORD, 32'h40);
    rd(`ITC_OFS_CNT1, 32'h77);
    wr(`ITC_OFS_CTRL_WORD, 32'h60);
    wr(`ITC_OFS_CNT1, 32'h05);
    wr(`ITC_OFS_CTRL_WORD, 32'h40);
    rd(`ITC_OFS_CNT1, 32'h05);
    gate <= 2'b11;
    // counter 2 runs only when its gate bit is set
    wr(`ITC_OFS_CTRL_WORD, 32'hB0);
    wr(`ITC_OFS_CNT2, 32'h05);
    wr(`ITC_OFS_CNT2, 32'h00);
    wr(`ITC_OFS_IRQ_MASK, 32'h4);
    repeat (20) @(posedge clk);
    `CHK("out2 gated", 1'b0, tout[2])
    `CHK("out1 counting", 1'b0, tout[1])
    `CHK("irq idle", 1'b0, irq)
    wr(`ITC_OFS_SYS_PORT, 32'h3);
    repeat (20) @(posedge clk);
    `CHK("out2", 1'b1, tout[2])
    `CHK("speaker", 1'b1, speaker)
    `CHK("irq", 1'b1, irq)
    rd(`ITC_OFS_SYS_PORT, 32'h23, 32'hFFFFFFEF);
    rd(`ITC_OFS_IRQ_STAT, 32'h4, 32'h4);
    wr(`ITC_OFS_IRQ_MASK, 32'h0);
    repeat (3) @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    wr(`ITC_OFS_IRQ_MASK, 32'h4);
    wr(`ITC_OFS_IRQ_STAT, 32'h4);
    repeat (3) @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    wr(`ITC_OFS_CTRL_WORD, 32'hE8);
    rd(`ITC_OFS_CNT2, 32'hB0);
    wr(`ITC_OFS_SYS_PORT, 32'h1);
    repeat (3) @(posedge clk);
    `CHK("speaker off", 1'b0, speaker)
    rd(`ITC_OFS_SYS_PORT, 32'h0, 32'h0);
    a = rq;
    repeat (12) @(posedge clk);
    rd(`ITC_OFS_SYS_PORT, 32'h0, 32'h0);
    `CHK("refresh", ~a[4], rq[4])
    // random enables, error levels and system port writes
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      serr <= v[4];
      iochk <= v[5];
      wr(`ITC_OFS_SYS_PORT, v);
      repeat (3) @(posedge clk);
      `CHK("nmi", (v[4] & v[2]) | (v[5] & v[3]), nmi)
      rd(`ITC_OFS_SYS_PORT, {24'h0, v[4], v[5], 2'b00, v[3:0]},
         32'hFFFFFFCF);
    end
    end_of_test();
  end
endmodule // itc_top_tb_top
